// >>> rtl/uhtr_pkg.sv
// Package of constants for the host transfer and resume control block
// Operation
// R1: Remote wakeup on port starts resume signalling
// R2: Resume held for 20 ms, then ends
// R3: Operational state mid-resume ends it with EOP
// R4: Software issues port resume after going operational
// R5: Short IN: status write, then retirement write
// R6: Frame boundary before status done: skip, retry IN
// R7: Memory grants status writes within the frame
// R8: Prefetch 16 ISO OUT bytes before token
// R9: Underrun during stuffed bit must not hang SOF
// R10: Memory keeps ISO OUT transmit buffer fed
// R11: Underrun ends packet, records error, SOF continues
package uhtr_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned RESUME_MS = 20;
    localparam int unsigned RESUME_CYCLES = (CLK_HZ / 1000) * RESUME_MS;
    // ------------------------------------------------------------
    // Isochronous OUT prefetch
    // ------------------------------------------------------------
    localparam int unsigned ISO_PREFETCH_BYTES = 16;
    // ------------------------------------------------------------
    // Memory write kinds and status codes
    // ------------------------------------------------------------
    localparam logic [1:0] WR_STATUS = 2'h1;
    localparam logic [1:0] WR_RETIRE = 2'h2;
    localparam logic [3:0] CC_NO_ERROR = 4'h0;
    localparam logic [3:0] CC_UNDERRUN = 4'hd;
    // ------------------------------------------------------------
    // Host functional states
    // ------------------------------------------------------------
    localparam logic [1:0] HFS_RESET = 2'h0;
    localparam logic [1:0] HFS_RESUME = 2'h1;
    localparam logic [1:0] HFS_OPERATIONAL = 2'h2;
    localparam logic [1:0] HFS_SUSPEND = 2'h3;
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_DRIVE = 2'b01,
        RS_EOP = 2'b10
    } uhtr_rs_e;
    typedef enum logic [2:0] {
        IN_IDLE = 3'b000,
        IN_STATUS = 3'b001,
        IN_RETIRE = 3'b010,
        IN_RETRY = 3'b011
    } uhtr_in_e;
    typedef enum logic [2:0] {
        OS_IDLE = 3'b000,
        OS_FETCH = 3'b001,
        OS_TOKEN = 3'b010,
        OS_SEND = 3'b011,
        OS_ABORT = 3'b100
    } uhtr_os_e;
endpackage

// >>> rtl/uhtr_buf2.sv
// Small buffer with valid and ready on both sides, two entries by default
`timescale 1ns/1ps
`default_nettype none
module uhtr_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != FULL);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
        end
        wr_nxt = wr_r;
        if (push) begin
            wr_nxt = (wr_r == LAST) ? '0 : wr_r + AW'(1);
        end
        rd_nxt = rd_r;
        if (pop) begin
            rd_nxt = (rd_r == LAST) ? '0 : rd_r + AW'(1);
        end
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_r <= '{default: '0};
            cnt_r <= '0;
            rd_r <= '0;
            wr_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
        end
    end
endmodule // uhtr_buf2
`default_nettype wire

// >>> rtl/uhtr_top.sv
// Host transfer completion, isochronous OUT feed and resume control
`timescale 1ns/1ps
`default_nettype none
module uhtr_top #(
    parameter int unsigned RESUME_CYCLES = uhtr_pkg::RESUME_CYCLES,
    parameter int unsigned PREFETCH = uhtr_pkg::ISO_PREFETCH_BYTES
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    // Port and host state
    input wire logic WAKE_PIN,
    input wire logic [1:0] HFS,
    output logic RESUME_DRIVE,
    output logic RESUME_EOP,
    // Frame timing
    input wire logic FRAME_TICK,
    output logic SOF_SEND,
    // Short IN completion
    input wire logic IN_SHORT_DONE,
    output logic MEM_WR_REQ,
    output logic [1:0] MEM_WR_KIND,
    output logic [3:0] MEM_WR_CC,
    input wire logic MEM_WR_ACK,
    output logic IN_TOKEN_RETRY,
    // Isochronous OUT
    input wire logic ISO_START,
    input wire logic [10:0] ISO_LEN,
    input wire logic MEM_RD_VALID,
    output logic MEM_RD_READY,
    input wire logic [7:0] MEM_RD_DATA,
    output logic OUT_TOKEN,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [7:0] TX_DATA,
    input wire logic TX_STUFFING,
    output logic TX_EOP,
    output logic ISO_UNDERRUN
);
    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic wake_s1_r, wake_s2_r, wake_d_r;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
            wake_d_r <= 1'b0;
        end else begin
            wake_s1_r <= WAKE_PIN;
            wake_s2_r <= wake_s1_r;
            wake_d_r <= wake_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Resume signalling
    // ------------------------------------------------------------
    uhtr_pkg::uhtr_rs_e rs_r, rs_nxt;
    logic [31:0] rs_cnt_r, rs_cnt_nxt;
    always_comb begin
        rs_nxt = rs_r;
        rs_cnt_nxt = rs_cnt_r;
        unique case (rs_r)
            uhtr_pkg::RS_IDLE: begin
                if (wake_s2_r && !wake_d_r) begin
                    rs_nxt = uhtr_pkg::RS_DRIVE; // [R1]
                    rs_cnt_nxt = 32'h0;
                end
            end
            uhtr_pkg::RS_DRIVE: begin
                rs_cnt_nxt = rs_cnt_r + 32'h1;
                if (HFS == uhtr_pkg::HFS_OPERATIONAL) begin
                    rs_nxt = uhtr_pkg::RS_EOP; // [R3]
                end else if (rs_cnt_r == RESUME_CYCLES - 1) begin
                    rs_nxt = uhtr_pkg::RS_EOP; // [R2]
                end
            end
            uhtr_pkg::RS_EOP: begin
                rs_nxt = uhtr_pkg::RS_IDLE;
            end
            default: begin
                rs_nxt = uhtr_pkg::RS_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rs_r <= uhtr_pkg::RS_IDLE;
            rs_cnt_r <= 32'h0;
        end else begin
            rs_r <= rs_nxt;
            rs_cnt_r <= rs_cnt_nxt;
        end
    end
    assign RESUME_DRIVE = (rs_r == uhtr_pkg::RS_DRIVE);
    assign RESUME_EOP = (rs_r == uhtr_pkg::RS_EOP);

    // ------------------------------------------------------------
    // Short IN status update
    // ------------------------------------------------------------
    uhtr_pkg::uhtr_in_e in_r, in_nxt;
    logic frame_seen_r, frame_seen_nxt;
    always_comb begin
        in_nxt = in_r;
        frame_seen_nxt = frame_seen_r;
        unique case (in_r)
            uhtr_pkg::IN_IDLE: begin
                frame_seen_nxt = 1'b0;
                if (IN_SHORT_DONE) begin
                    in_nxt = uhtr_pkg::IN_STATUS; // [R5]
                end
            end
            uhtr_pkg::IN_STATUS: begin
                if (FRAME_TICK) begin
                    frame_seen_nxt = 1'b1;
                end
                if (MEM_WR_ACK) begin
                    if (frame_seen_r || FRAME_TICK) begin
                        in_nxt = uhtr_pkg::IN_RETRY; // [R6]
                    end else begin
                        in_nxt = uhtr_pkg::IN_RETIRE; // [R5]
                    end
                end
            end
            uhtr_pkg::IN_RETIRE: begin
                if (MEM_WR_ACK) begin
                    in_nxt = uhtr_pkg::IN_IDLE;
                end
            end
            uhtr_pkg::IN_RETRY: begin
                in_nxt = uhtr_pkg::IN_IDLE;
            end
            default: begin
                in_nxt = uhtr_pkg::IN_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            in_r <= uhtr_pkg::IN_IDLE;
            frame_seen_r <= 1'b0;
        end else begin
            in_r <= in_nxt;
            frame_seen_r <= frame_seen_nxt;
        end
    end
    assign IN_TOKEN_RETRY = (in_r == uhtr_pkg::IN_RETRY); // [R6]

    // ------------------------------------------------------------
    // Isochronous OUT feed
    // ------------------------------------------------------------
    uhtr_pkg::uhtr_os_e os_r, os_nxt;
    logic [10:0] fetched_r, fetched_nxt, sent_r, sent_nxt, len_r, len_nxt;
    logic ur_r, ur_nxt;
    logic buf_in_ready, buf_out_valid, fetch_en;
    assign fetch_en = (os_r == uhtr_pkg::OS_FETCH || os_r == uhtr_pkg::OS_TOKEN || os_r == uhtr_pkg::OS_SEND)
                      && (fetched_r < len_r);
    assign MEM_RD_READY = fetch_en && buf_in_ready;
    // Deep enough to hold the whole prefetch before the token
    uhtr_buf2 #(.WIDTH(8), .DEPTH(PREFETCH)) u_buf (
        .clk(CLK),
        .rst(SYS_RST),
        .in_valid(MEM_RD_VALID && fetch_en),
        .in_ready(buf_in_ready),
        .in_data(MEM_RD_DATA),
        .out_valid(buf_out_valid),
        .out_ready(TX_READY && os_r == uhtr_pkg::OS_SEND),
        .out_data(TX_DATA)
    );
    always_comb begin
        os_nxt = os_r;
        len_nxt = len_r;
        fetched_nxt = fetched_r + {10'h0, MEM_RD_VALID && MEM_RD_READY};
        sent_nxt = sent_r;
        ur_nxt = ur_r;
        unique case (os_r)
            uhtr_pkg::OS_IDLE: begin
                if (ISO_START) begin
                    os_nxt = uhtr_pkg::OS_FETCH;
                    len_nxt = ISO_LEN;
                    fetched_nxt = 11'h0;
                    sent_nxt = 11'h0;
                    ur_nxt = 1'b0;
                end
            end
            uhtr_pkg::OS_FETCH: begin
                // Prefetch whole packet if shorter than the prefetch depth
                if (fetched_r >= len_r || fetched_r >= PREFETCH[10:0]) begin
                    os_nxt = uhtr_pkg::OS_TOKEN; // [R8]
                end
            end
            uhtr_pkg::OS_TOKEN: begin
                os_nxt = uhtr_pkg::OS_SEND; // [R8]
            end
            uhtr_pkg::OS_SEND: begin
                if (TX_READY && buf_out_valid) begin
                    sent_nxt = sent_r + 11'h1;
                end
                if (sent_r == len_r) begin
                    os_nxt = uhtr_pkg::OS_IDLE;
                end else if (TX_READY && !buf_out_valid) begin
                    // Underrun, even mid stuffed bit, closes the packet
                    ur_nxt = 1'b1; // [R11] [R9]
                    os_nxt = uhtr_pkg::OS_ABORT;
                end
            end
            uhtr_pkg::OS_ABORT: begin
                // Hold the abort until any stuffed bit has gone out
                if (!TX_STUFFING) begin
                    os_nxt = uhtr_pkg::OS_IDLE; // [R11]
                end
            end
            default: begin
                os_nxt = uhtr_pkg::OS_IDLE;
            end
        endcase
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            os_r <= uhtr_pkg::OS_IDLE;
            len_r <= 11'h0;
            fetched_r <= 11'h0;
            sent_r <= 11'h0;
            ur_r <= 1'b0;
        end else begin
            os_r <= os_nxt;
            len_r <= len_nxt;
            fetched_r <= fetched_nxt;
            sent_r <= sent_nxt;
            ur_r <= ur_nxt;
        end
    end
    assign OUT_TOKEN = (os_r == uhtr_pkg::OS_TOKEN);
    assign TX_VALID = buf_out_valid && os_r == uhtr_pkg::OS_SEND;
    // EOP is driven only once any stuffed bit has gone out
    assign TX_EOP = (os_r == uhtr_pkg::OS_ABORT) && !TX_STUFFING; // [R9]
    assign ISO_UNDERRUN = ur_r;

    // ------------------------------------------------------------
    // Descriptor writes and SOF
    // ------------------------------------------------------------
    always_comb begin
        MEM_WR_REQ = 1'b0;
        MEM_WR_KIND = 2'h0;
        MEM_WR_CC = uhtr_pkg::CC_NO_ERROR;
        if (in_r == uhtr_pkg::IN_STATUS) begin
            MEM_WR_REQ = 1'b1;
            MEM_WR_KIND = uhtr_pkg::WR_STATUS;
        end else if (in_r == uhtr_pkg::IN_RETIRE) begin
            MEM_WR_REQ = 1'b1;
            MEM_WR_KIND = uhtr_pkg::WR_RETIRE;
        end else if (os_r == uhtr_pkg::OS_ABORT && !TX_STUFFING) begin
            MEM_WR_REQ = 1'b1;
            MEM_WR_KIND = uhtr_pkg::WR_STATUS;
            MEM_WR_CC = uhtr_pkg::CC_UNDERRUN; // [R11]
        end
    end
    // SOF never depends on transmit state, so it survives any underrun
    assign SOF_SEND = FRAME_TICK; // [R11] [R9]
endmodule // uhtr_top
`default_nettype wire

// >>> testbench/uhtr_top_asserts.sv
// Checker for the transfer and resume control block
`timescale 1ns/1ps
`default_nettype none
module uhtr_asserts #(
    parameter int unsigned RESUME_CYCLES = 100,
    parameter int unsigned PREFETCH = 16
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic WAKE_PIN,
    input wire logic [1:0] HFS,
    input wire logic RESUME_DRIVE,
    input wire logic RESUME_EOP,
    input wire logic FRAME_TICK,
    input wire logic SOF_SEND,
    input wire logic IN_SHORT_DONE,
    input wire logic MEM_WR_REQ,
    input wire logic [1:0] MEM_WR_KIND,
    input wire logic [3:0] MEM_WR_CC,
    input wire logic MEM_WR_ACK,
    input wire logic IN_TOKEN_RETRY,
    input wire logic ISO_START,
    input wire logic [10:0] ISO_LEN,
    input wire logic MEM_RD_VALID,
    input wire logic MEM_RD_READY,
    input wire logic OUT_TOKEN,
    input wire logic TX_STUFFING,
    input wire logic TX_EOP,
    input wire logic ISO_UNDERRUN
);
    // ----
    // Helper counters
    // ----
    logic [31:0] drv_r, drv_nxt;
    logic [10:0] len_r, len_nxt, fet_r, fet_nxt;
    always_comb begin
        drv_nxt = RESUME_DRIVE ? drv_r + 32'h1 : 32'h0;
        len_nxt = ISO_START ? ISO_LEN : len_r;
        fet_nxt = ISO_START ? 11'h0 : fet_r + {10'h0, MEM_RD_VALID & MEM_RD_READY};
    end
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            drv_r <= 32'h0;
            len_r <= 11'h0;
            fet_r <= 11'h0;
        end else begin
            drv_r <= drv_nxt;
            len_r <= len_nxt;
            fet_r <= fet_nxt;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // ----
    // Properties
    // ----
    AST_WAKE_START: assert property ($rose(WAKE_PIN) && !RESUME_DRIVE && !RESUME_EOP && HFS != 2'h2
        |-> ##3 RESUME_DRIVE) else $error("resume not started by wakeup");
    AST_RESUME_LEN: assert property ($fell(RESUME_DRIVE) && $past(HFS) != 2'h2
        |-> drv_r == RESUME_CYCLES) else $error("resume length wrong");
    AST_EOP_ONE: assert property (RESUME_EOP |-> ($past(RESUME_DRIVE) && !RESUME_DRIVE) ##1 !RESUME_EOP)
        else $error("resume end pulse wrong");
    AST_EARLY_END: assert property (RESUME_DRIVE && HFS == 2'h2 |=> !RESUME_DRIVE && RESUME_EOP)
        else $error("resume not ended early");
    AST_STATUS_FIRST: assert property (IN_SHORT_DONE && !MEM_WR_REQ && !IN_TOKEN_RETRY
        |=> MEM_WR_REQ && MEM_WR_KIND == uhtr_pkg::WR_STATUS) else $error("status write missing");
    AST_STATUS_HOLD: assert property (MEM_WR_REQ && !MEM_WR_ACK && MEM_WR_CC == uhtr_pkg::CC_NO_ERROR
        |=> MEM_WR_REQ && $stable(MEM_WR_KIND)) else $error("write request dropped");
    AST_RETRY: assert property (IN_TOKEN_RETRY |-> ($past(MEM_WR_ACK) && !MEM_WR_REQ) ##1 !MEM_WR_REQ)
        else $error("retry with retirement");
    AST_PREFETCH: assert property (OUT_TOKEN
        |-> fet_r >= ((len_r < 11'(PREFETCH)) ? len_r : 11'(PREFETCH))) else $error("token before prefetch");
    AST_UNDERRUN: assert property (MEM_WR_REQ && MEM_WR_CC == uhtr_pkg::CC_UNDERRUN
        |-> (MEM_WR_KIND == uhtr_pkg::WR_STATUS && TX_EOP == !TX_STUFFING) ##1 ISO_UNDERRUN)
        else $error("underrun handling wrong");
    AST_SOF: assert property (SOF_SEND == FRAME_TICK)
        else $error("start of frame lost");
endmodule // uhtr_asserts
bind uhtr_top uhtr_asserts #(.RESUME_CYCLES(RESUME_CYCLES), .PREFETCH(PREFETCH)) u_chk (.*);
`default_nettype wire

// >>> testbench/uhtr_dev_model.sv
// Model of the USB device on the port
`timescale 1ns/1ps
`default_nettype none
module uhtr_dev_model (
    input wire logic clk,
    input wire logic wake,
    input wire logic stall,
    input wire logic stuff,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic wake_pin,
    output logic tx_ready,
    output logic tx_stuffing
);
    logic [7:0] rx_q[$];
    initial begin
        wake_pin = 1'b0;
        tx_ready = 1'b0;
        tx_stuffing = 1'b0;
    end
    always @(posedge clk) begin
        wake_pin <= wake;
        tx_ready <= !stall;
        tx_stuffing <= stuff;
        if (tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
        end
    end
endmodule // uhtr_dev_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the transfer and resume control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic CLK = 1'b0, SYS_RST = 1'b1, FRAME_TICK = 1'b0, IN_SHORT_DONE = 1'b0, MEM_WR_ACK = 1'b0;
    logic ISO_START = 1'b0, MEM_RD_VALID = 1'b0, wake = 1'b0, stall = 1'b0, stuff = 1'b0;
    logic [1:0] HFS = uhtr_pkg::HFS_SUSPEND;
    logic [10:0] ISO_LEN = 11'h0;
    logic [7:0] MEM_RD_DATA = 8'h0;
    logic WAKE_PIN, TX_READY, TX_STUFFING, RESUME_DRIVE, RESUME_EOP, SOF_SEND, MEM_WR_REQ, IN_TOKEN_RETRY;
    logic MEM_RD_READY, OUT_TOKEN, TX_VALID, TX_EOP, ISO_UNDERRUN;
    logic [1:0] MEM_WR_KIND;
    logic [3:0] MEM_WR_CC;
    logic [7:0] TX_DATA;
    int error_cnt = 0, tests_run = 0, cyc = 0, fed = 0;
    uhtr_top #(.RESUME_CYCLES(100), .PREFETCH(16)) dut (.*);
    uhtr_dev_model u_dev (.clk(CLK), .wake(wake), .stall(stall), .stuff(stuff), .tx_valid(TX_VALID),
        .tx_data(TX_DATA), .wake_pin(WAKE_PIN), .tx_ready(TX_READY), .tx_stuffing(TX_STUFFING));
    always #12.5 CLK = ~CLK;
    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic feed(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            MEM_RD_VALID <= 1'b1;
            MEM_RD_DATA <= 8'h40 + 8'(i);
            @(posedge CLK);
            while (MEM_RD_READY !== 1'b1) @(posedge CLK);
            fed++;
        end
        MEM_RD_VALID <= 1'b0;
    endtask
    task automatic t_resume(input logic early);
        int n;
        n = 0;
        wake <= 1'b1;
        while (RESUME_DRIVE !== 1'b1 && n < 10) begin
            @(posedge CLK);
            n++;
        end
        chk(RESUME_DRIVE, 1);
        n = 0;
        while (RESUME_DRIVE === 1'b1 && n < 200) begin
            n++;
            if (early && n == 5) HFS <= uhtr_pkg::HFS_OPERATIONAL;
            @(posedge CLK);
        end
        chk(RESUME_EOP, 1);
        if (early) chk(n, 6);
        else chk(n, 100);
        wake <= 1'b0;
        HFS <= uhtr_pkg::HFS_SUSPEND;
        repeat (4) @(posedge CLK);
        $display("resume test done");
    endtask
    task automatic t_short(input logic tick);
        int n;
        logic rt, rr;
        n = 0;
        rt = 1'b0;
        rr = 1'b0;
        IN_SHORT_DONE <= 1'b1;
        @(posedge CLK);
        IN_SHORT_DONE <= 1'b0;
        while (MEM_WR_REQ !== 1'b1 && n < 8) begin
            @(posedge CLK);
            n++;
        end
        chk(MEM_WR_KIND, uhtr_pkg::WR_STATUS);
        FRAME_TICK <= tick;
        @(posedge CLK);
        FRAME_TICK <= 1'b0;
        MEM_WR_ACK <= 1'b1;
        @(posedge CLK);
        MEM_WR_ACK <= 1'b0;
        repeat (6) begin
            @(posedge CLK);
            rt |= IN_TOKEN_RETRY;
            MEM_WR_ACK <= MEM_WR_REQ && MEM_WR_KIND == uhtr_pkg::WR_RETIRE && !rr;
            rr |= MEM_WR_REQ && MEM_WR_KIND == uhtr_pkg::WR_RETIRE;
        end
        chk(rt, tick);
        chk(rr, !tick);
        $display("short IN test done");
    endtask
    task automatic t_iso();
        int n;
        n = 0;
        fed = 0;
        u_dev.rx_q.delete();
        stall <= 1'b1;
        ISO_LEN <= 11'd20;
        ISO_START <= 1'b1;
        @(posedge CLK);
        ISO_START <= 1'b0;
        fork
            feed(20);
            begin
                while (OUT_TOKEN !== 1'b1 && n < 100) begin
                    @(posedge CLK);
                    n++;
                end
                chk(OUT_TOKEN, 1);
                chk(fed >= 16, 1);
                repeat (12) @(posedge CLK);
                stall <= 1'b0;
            end
        join
        repeat (60) @(posedge CLK);
        chk(u_dev.rx_q.size(), 20);
        for (int i = 0; i < 20; i++) chk(u_dev.rx_q[i], 8'h40 + 8'(i));
        chk(ISO_UNDERRUN, 0);
        $display("iso out test done");
    endtask
    task automatic t_under(input logic stf);
        logic cc, eop;
        cc = 1'b0;
        eop = 1'b0;
        stuff <= stf;
        ISO_LEN <= 11'd20;
        ISO_START <= 1'b1;
        @(posedge CLK);
        ISO_START <= 1'b0;
        feed(16);
        repeat (30) begin
            @(posedge CLK);
            cc |= MEM_WR_REQ && MEM_WR_CC == uhtr_pkg::CC_UNDERRUN;
            eop |= TX_EOP;
        end
        chk(eop, !stf);
        chk(cc, !stf);
        chk(ISO_UNDERRUN, 1);
        stuff <= 1'b0;
        repeat (10) begin
            @(posedge CLK);
            cc |= MEM_WR_REQ && MEM_WR_CC == uhtr_pkg::CC_UNDERRUN;
            eop |= TX_EOP;
        end
        chk(cc, 1);
        chk(eop, 1);
        FRAME_TICK <= 1'b1;
        @(posedge CLK);
        chk(SOF_SEND, 1);
        FRAME_TICK <= 1'b0;
        stuff <= 1'b0;
        $display("underrun test done");
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        t_resume(1'b0);
        t_resume(1'b1);
        t_short(1'b0);
        t_short(1'b1);
        t_iso();
        t_under(1'b1);
        t_under(1'b0);
        results();
    end
endmodule // testbench
`default_nettype wire
